// [rtl/rtc_params.svh]
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define A_CNT0 8'h04
`define A_CNT1 8'h05
`define A_CNT2 8'h06
`define A_CTRL 8'h07
`define A_STAT 8'h08
`define A_CHRG 8'h10
// ****************************************
// field positions
// ****************************************
`define B_HALT 7
`define B_CEN 6
`define B_MODE 5
`define B_BBSQ 4
`define B_STEER 3
`define B_RSHI 2
`define B_RSLO 1
`define B_IRQ_EN 0
`define B_STOP_FLAG 7
`define B_CD_FLAG 0
// ****************************************
// reset values and keys
// ****************************************
`define CTRL_RST 8'h06
`define CHRG_RST 8'h00
`define CHRG_KEY 4'hA
`define DIODE_NONE 2'h1
`define DIODE_ONE 2'h2
`define RES_OFF 2'h0
// ****************************************
// timing
// ****************************************
`define CLK_HZ 200000000
`define OSC_HZ 32768
`define BASE_CYC (`CLK_HZ / (2 * `OSC_HZ))
`define TICK_HZ 4096
`define PULSE_MS 250
`define PULSE_TICKS ((`PULSE_MS * `TICK_HZ) / 1000)
`endif

// [rtl/rtc_pkg.sv]
package rtc_pkg;
    typedef enum logic [1:0]
    {
        PS_IDLE = 2'b00,
        PS_RST  = 2'b01,
        PS_INT  = 2'b11
    } pulse_state_type;
endpackage : rtc_pkg

// [rtl/rtc_control_status_regs.sv]
// Behaviour
// [RULE1] oscillator runs while halt bit is 0, stops into standby when 1
// [RULE2] on main supply the oscillator always runs
// [RULE3] power-up clears control bits except both rate selects, which are set
// [RULE4] countdown runs only when enabled, else its bytes are plain storage
// [RULE5] mode 0 decrements each second, reloads from seed at zero
// [RULE6] mode 1 decrements at 4096 Hz, sets flag at zero and stops
// [RULE7] any counter access before zero reloads from seed and restarts
// [RULE8] backup wave enable keeps square wave driven, else floats on supply fail
// [RULE9] steering 0 in mode 1 gives 250 ms reset pulse at zero
// [RULE10] steering 1 sends the 250 ms pulse to the interrupt pin
// [RULE11] rate select picks 1 Hz, 4.096, 8.192 or 32.768 kHz
// [RULE12] flag drives interrupt only with irq enable and output select set; the mode 1 interrupt pulse ignores output select
// [RULE13] a started interrupt pulse completes even if irq enable is cleared
// [RULE14] interrupt pin works on either supply
// [RULE15] oscillator stopped flag sets on any stop, clears only by writing 0
// [RULE16] mode 0 with irq enable holds interrupt low until flag cleared
// [RULE17] writing 0 clears the countdown flag, writing 1 leaves it
// [RULE18] mode 1 pulse lasts 250 ms, clears flag at end, not shortened
// [RULE19] charger enabled only with unlock pattern 1010
// [RULE20] diode choice 01 none, 10 one, 00 and 11 disable
// [RULE21] resistor choice 01, 10, 11 select a value, 00 disables
// [RULE22] counter write loads counter and seed; reloads use the seed
// [RULE23] unused status bits read zero and ignore writes
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_control_status_regs #(
    parameter int BASE_CYCLES = `BASE_CYC
)(
    input  wire logic                    I_CLK,
    input  wire logic                    I_RST,
    input  wire logic [7:0]              I_REG_ADDR,
    input  wire logic                    I_REG_WR,
    input  wire logic                    I_REG_RD,
    input  wire logic [7:0]              I_REG_WDATA,
    input  wire logic                    I_ON_BACKUP,
    input  wire logic                    I_VCC_FAIL,
    input  wire logic                    I_IRQ_OUTPUT_SELECT,
    output logic      [7:0]              O_REG_RDATA,
    output logic                         O_WAVE,
    output logic                         O_WAVE_OE,
    output logic                         O_RST_OUT,
    output logic                         O_RST_OE,
    output logic                         O_IRQ_OUT,
    output logic                         O_IRQ_OE,
    output logic                         O_CHARGE_EN,
    output logic                         O_DIODE_SEL,
    output logic      [1:0]              O_RES_SEL,
    output logic                         O_STANDBY,
    output rtc_pkg::pulse_state_type     O_PULSE_STATE
);
    import rtc_pkg::*;

    // ****************************************
    // oscillator model and prescaler
    // ****************************************
    logic [11:0] div;
    logic [11:0] next_div;
    logic [15:0] pre;
    logic [15:0] next_pre;
    logic        osc_run;
    logic        base_tick;
    logic        tick4k;
    logic        tick1;
    logic [7:0]  ctrl;

    // on main supply the halt bit has no effect
    assign osc_run = !ctrl[`B_HALT] || !I_ON_BACKUP; // [RULE1] [RULE2]
    assign base_tick = osc_run && (div == 12'(BASE_CYCLES - 1));
    assign tick4k = base_tick && (pre[3:0] == 4'hF);
    assign tick1 = base_tick && (pre == 16'hFFFF);

    always_comb
    begin
        next_div = div;
        next_pre = pre;
        if (osc_run)
        begin
            next_div = base_tick ? 12'h000 : div + 12'h001;
            if (base_tick)
            begin
                next_pre = pre + 16'h0001;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            div <= 12'h000;
            pre <= 16'h0000;
        end
        else
        begin
            div <= next_div;
            pre <= next_pre;
        end
    end

    // ****************************************
    // registers, countdown and pulse
    // ****************************************
    logic [7:0]      next_ctrl;
    logic [7:0]      chrg;
    logic [7:0]      next_chrg;
    logic            stop_flag;
    logic            next_stop_flag;
    logic            cd_flag;
    logic            next_cd_flag;
    logic [23:0]     cnt;
    logic [23:0]     next_cnt;
    logic [23:0]     seed;
    logic [23:0]     next_seed;
    pulse_state_type pst;
    pulse_state_type next_pst;
    logic [10:0]     pcnt;
    logic [10:0]     next_pcnt;
    logic            cnt_addr;
    logic            wr_stat;
    logic            cd_tick;
    logic            zero_ev;
    logic            pulse_end;

    assign cnt_addr = (I_REG_ADDR == `A_CNT0) || (I_REG_ADDR == `A_CNT1)
                   || (I_REG_ADDR == `A_CNT2);
    assign wr_stat = I_REG_WR && (I_REG_ADDR == `A_STAT);
    assign cd_tick = ctrl[`B_MODE] ? tick4k : tick1; // [RULE5] [RULE6]
    // counting is held during a pulse so a write restarts after it
    assign zero_ev = ctrl[`B_CEN] && cd_tick && (pst == PS_IDLE)
                  && (cnt == 24'h000001) && !(cnt_addr && (I_REG_WR || I_REG_RD));
    assign pulse_end = (pst != PS_IDLE) && tick4k
                    && (pcnt == 11'(`PULSE_TICKS - 1));

    always_comb
    begin
        next_ctrl = ctrl;
        next_chrg = chrg;
        next_stop_flag = stop_flag;
        next_cd_flag = cd_flag;
        next_cnt = cnt;
        next_seed = seed;
        next_pst = pst;
        next_pcnt = pcnt;
        if (I_REG_WR && (I_REG_ADDR == `A_CTRL))
        begin
            next_ctrl = I_REG_WDATA;
        end
        if (I_REG_WR && (I_REG_ADDR == `A_CHRG))
        begin
            next_chrg = I_REG_WDATA;
        end
        // only bits 7 and 0 are stored; set wins over a clear
        if (wr_stat && !I_REG_WDATA[`B_STOP_FLAG])
        begin
            next_stop_flag = 1'b0; // [RULE15]
        end
        if (!osc_run)
        begin
            next_stop_flag = 1'b1; // [RULE15]
        end
        if (wr_stat && !I_REG_WDATA[`B_CD_FLAG])
        begin
            next_cd_flag = 1'b0; // [RULE17]
        end
        if (pulse_end)
        begin
            next_cd_flag = 1'b0; // [RULE18]
        end
        if (I_REG_WR && cnt_addr)
        begin
            if (I_REG_ADDR == `A_CNT0)
            begin
                next_seed[7:0] = I_REG_WDATA;
            end
            else if (I_REG_ADDR == `A_CNT1)
            begin
                next_seed[15:8] = I_REG_WDATA;
            end
            else
            begin
                next_seed[23:16] = I_REG_WDATA;
            end
            next_cnt = next_seed; // [RULE22]
        end
        else if (I_REG_RD && cnt_addr && (cnt != 24'h000000))
        begin
            next_cnt = seed; // [RULE7]
        end
        else if (zero_ev)
        begin
            next_cd_flag = 1'b1;
            // periodic mode reloads, watchdog mode stops at zero
            next_cnt = ctrl[`B_MODE] ? 24'h000000 : seed; // [RULE5] [RULE6]
        end
        else if (ctrl[`B_CEN] && cd_tick && (pst == PS_IDLE) && (cnt != 24'h000000))
        begin
            next_cnt = cnt - 24'h000001; // [RULE4]
        end
        case (pst)
            PS_IDLE:
            begin
                next_pcnt = 11'h000;
                if (zero_ev && ctrl[`B_MODE])
                begin
                    if (!ctrl[`B_STEER])
                    begin
                        next_pst = PS_RST; // [RULE9]
                    end
                    else if (ctrl[`B_IRQ_EN])
                    begin
                        next_pst = PS_INT; // [RULE10]
                    end
                end
            end
            default:
            begin
                // enable and flag writes are not looked at here
                if (pulse_end)
                begin
                    next_pst = PS_IDLE; // [RULE13]
                end
                else if (tick4k)
                begin
                    next_pcnt = pcnt + 11'h001;
                end
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ctrl <= `CTRL_RST; // [RULE3]
            chrg <= `CHRG_RST;
            stop_flag <= 1'b1; // [RULE15]
            cd_flag <= 1'b0;
            cnt <= 24'h000000;
            seed <= 24'h000000;
            pst <= PS_IDLE;
            pcnt <= 11'h000;
        end
        else
        begin
            ctrl <= next_ctrl;
            chrg <= next_chrg;
            stop_flag <= next_stop_flag;
            cd_flag <= next_cd_flag;
            cnt <= next_cnt;
            seed <= next_seed;
            pst <= next_pst;
            pcnt <= next_pcnt;
        end
    end

    // ****************************************
    // registered outputs
    // ****************************************
    logic [7:0] next_rdata;
    logic       next_wave;
    logic       next_irq_oe;
    logic       next_chg_en;

    always_comb
    begin
        next_rdata = O_REG_RDATA;
        if (I_REG_RD)
        begin
            if (I_REG_ADDR == `A_CNT0)
            begin
                next_rdata = cnt[7:0];
            end
            else if (I_REG_ADDR == `A_CNT1)
            begin
                next_rdata = cnt[15:8];
            end
            else if (I_REG_ADDR == `A_CNT2)
            begin
                next_rdata = cnt[23:16];
            end
            else if (I_REG_ADDR == `A_CTRL)
            begin
                next_rdata = ctrl;
            end
            else if (I_REG_ADDR == `A_STAT)
            begin
                next_rdata = {stop_flag, 6'h00, cd_flag}; // [RULE23]
            end
            else if (I_REG_ADDR == `A_CHRG)
            begin
                next_rdata = chrg;
            end
            else
            begin
                next_rdata = 8'h00;
            end
        end
        case (ctrl[`B_RSHI:`B_RSLO]) // [RULE11]
            2'h0: next_wave = pre[15];
            2'h1: next_wave = pre[3];
            2'h2: next_wave = pre[2];
            default: next_wave = pre[0];
        endcase
        // no supply gating, so the pin works on backup too
        next_irq_oe = (next_pst == PS_INT) || (!ctrl[`B_MODE] && ctrl[`B_IRQ_EN]
                   && I_IRQ_OUTPUT_SELECT && next_cd_flag); // [RULE12] [RULE14] [RULE16]
        next_chg_en = (chrg[7:4] == `CHRG_KEY) // [RULE19]
                   && ((chrg[3:2] == `DIODE_NONE) || (chrg[3:2] == `DIODE_ONE))
                   && (chrg[1:0] != `RES_OFF); // [RULE20] [RULE21]
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_REG_RDATA <= 8'h00;
            O_WAVE <= 1'b0;
            O_WAVE_OE <= 1'b1;
            O_RST_OUT <= 1'b0;
            O_RST_OE <= 1'b0;
            O_IRQ_OUT <= 1'b0;
            O_IRQ_OE <= 1'b0;
            O_CHARGE_EN <= 1'b0;
            O_DIODE_SEL <= 1'b0;
            O_RES_SEL <= 2'h0;
            O_STANDBY <= 1'b0;
            O_PULSE_STATE <= PS_IDLE;
        end
        else
        begin
            O_REG_RDATA <= next_rdata;
            O_WAVE <= next_wave;
            O_WAVE_OE <= !I_VCC_FAIL || ctrl[`B_BBSQ]; // [RULE8]
            O_RST_OUT <= 1'b0;
            O_RST_OE <= (next_pst == PS_RST); // [RULE9]
            O_IRQ_OUT <= 1'b0;
            O_IRQ_OE <= next_irq_oe;
            O_CHARGE_EN <= next_chg_en;
            O_DIODE_SEL <= (chrg[3:2] == `DIODE_ONE); // [RULE20]
            O_RES_SEL <= chrg[1:0]; // [RULE21]
            O_STANDBY <= ctrl[`B_HALT] && I_ON_BACKUP; // [RULE1]
            O_PULSE_STATE <= next_pst;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_stop_sticky: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE15]
        !osc_run |=> stop_flag) else $error("osc stop flag not set");
    a_flag_keep: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE17]
        (wr_stat && I_REG_WDATA[`B_CD_FLAG] && cd_flag && !pulse_end) |=> cd_flag)
        else $error("writing one changed flag");
    a_flag_clear: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE17]
        (wr_stat && !I_REG_WDATA[`B_CD_FLAG] && !zero_ev) |=> !cd_flag)
        else $error("writing zero did not clear flag");
    a_main_run: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE2]
        !I_ON_BACKUP |-> osc_run ##1 !O_STANDBY)
        else $error("oscillator stopped on main supply");
    a_chg_lock: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE19]
        (chrg[7:4] != `CHRG_KEY) |=> !O_CHARGE_EN) else $error("charger unlocked");
    a_irq_hold: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE16]
        (!ctrl[`B_MODE] && ctrl[`B_IRQ_EN] && I_IRQ_OUTPUT_SELECT && cd_flag && !wr_stat)
        |=> O_IRQ_OE) else $error("alarm irq not held");
    a_irq_gate: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE12]
        (!I_IRQ_OUTPUT_SELECT && (next_pst != PS_INT)) |=> !O_IRQ_OE)
        else $error("irq driven without output select");
    a_pulse_run: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE13]
        (pst == PS_INT && !pulse_end) |=> (pst == PS_INT) && O_IRQ_OE)
        else $error("interrupt pulse cut short");
    a_rst_pulse: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE9]
        (zero_ev && ctrl[`B_MODE] && !ctrl[`B_STEER]) |=> O_RST_OE ##1 O_RST_OE)
        else $error("reset pulse missing");
    a_cnt_reload: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE7]
        (I_REG_RD && !I_REG_WR && cnt_addr && cnt != 24'h000000) |=> cnt == $past(seed))
        else $error("access did not reload counter");
    a_wave_float: assert property (@(posedge I_CLK) disable iff (I_RST) // [RULE8]
        (I_VCC_FAIL && !ctrl[`B_BBSQ]) |=> !O_WAVE_OE) else $error("wave pin not floated");
endmodule : rtc_control_status_regs

// [verif/rtc_host_model.sv]
`timescale 1ns/1ps
// ****************************************
// register port host
// ****************************************
module rtc_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic            o_wr,
    output logic            o_rd,
    output logic      [7:0] o_wdata
);
    initial
    begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // strobes last one cycle and are never high together
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        // released data no longer shows the written byte
        o_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        d = i_rdata;
    endtask : rd
endmodule : rtc_host_model

// [verif/test_rtc_control_status_regs.sv]
`timescale 1ns/1ps
module test_rtc_control_status_regs;
    import rtc_pkg::*;
    // ****************************************
    // bench signals
    // ****************************************
    logic            clk, rst, on_backup, vcc_fail, irq_sel, reg_wr, reg_rd;
    logic [7:0]      reg_addr, reg_wdata, rdata, v, w;
    logic            wave, wave_oe, rst_out, rst_oe, irq_out, irq_oe, chg_en, diode, standby;
    logic [1:0]      res_sel;
    pulse_state_type pstate;
    int              error_cnt, check_count, i;
    int              per[4] = '{0, 16, 8, 2};
    time             t0;
    rtc_host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(reg_addr), .o_wr(reg_wr),
        .o_rd(reg_rd), .o_wdata(reg_wdata));
    // one base tick per clock keeps the 250 ms pulse at 16384 cycles
    rtc_control_status_regs #(.BASE_CYCLES(1)) dut (.I_CLK(clk), .I_RST(rst),
        .I_REG_ADDR(reg_addr), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .I_REG_WDATA(reg_wdata),
        .I_ON_BACKUP(on_backup), .I_VCC_FAIL(vcc_fail), .I_IRQ_OUTPUT_SELECT(irq_sel),
        .O_REG_RDATA(rdata), .O_WAVE(wave), .O_WAVE_OE(wave_oe), .O_RST_OUT(rst_out),
        .O_RST_OE(rst_oe), .O_IRQ_OUT(irq_out), .O_IRQ_OE(irq_oe), .O_CHARGE_EN(chg_en),
        .O_DIODE_SEL(diode), .O_RES_SEL(res_sel), .O_STANDBY(standby), .O_PULSE_STATE(pstate));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ****************************************
    // checks and waits
    // ****************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp_len(input int got, input int exp, input int tol);
        check_count++;
        if (got < exp - tol || got > exp + tol)
        begin
            error_cnt++;
            $display("unexpected at %0t: length %0d want %0d", $time, got, exp);
        end
    endtask : cmp_len
    function automatic logic pick(input int which);
        return (which == 0) ? wave : (which == 1) ? rst_oe : irq_oe;
    endfunction : pick
    task automatic wait_lvl(input int which, input logic lvl, input int bound);
        int k;
        for (k = 0; k < bound; k++)
        begin
            if (pick(which) === lvl)
                return;
            @(negedge clk);
        end
        error_cnt++;
        $display("unexpected at %0t: wait ran out", $time);
        tally_and_finish();
    endtask : wait_lvl
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask : settle
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        rst = 1'b1;
        on_backup = 1'b0;
        vcc_fail = 1'b0;
        irq_sel = 1'b1;
        error_cnt = 0;
        check_count = 0;
        void'($urandom(32'hCDA9));
        repeat (8) @(negedge clk);
        rst = 1'b0;
        host.rd(8'h07, v); cmp8(v, 8'h06);
        host.rd(8'h08, v); cmp8(v, 8'h80);
        host.rd(8'h10, v); cmp8(v, 8'h00);
        host.rd(8'h20, v); cmp8(v, 8'h00);
        $display("reset values done");
        host.wr(8'h08, 8'hFF);
        host.rd(8'h08, v); cmp8(v, 8'h80);
        host.wr(8'h08, 8'h00);
        host.rd(8'h08, v); cmp8(v, 8'h00);
        $display("status bits done");
        for (i = 0; i < 16; i++)
        begin
            v = 8'($urandom());
            if (i[0])
                v[7:4] = 4'hA;
            host.wr(8'h10, v);
            settle();
            cmp8({7'h00, chg_en}, {7'h00, v[7:4] == 4'hA && (v[3:2] == 2'h1 || v[3:2] == 2'h2)
                && v[1:0] != 2'h0});
            cmp8({6'h00, res_sel}, {6'h00, v[1:0]});
            if (chg_en === 1'b1)
                cmp8({7'h00, diode}, {7'h00, v[3:2] == 2'h2});
            host.rd(8'h10, w);
            cmp8(w, v);
        end
        $display("charger done");
        on_backup = 1'b1;
        host.wr(8'h07, 8'h86);
        settle();
        cmp8({7'h00, standby}, 8'h01);
        host.wr(8'h08, 8'h00);
        host.rd(8'h08, v); cmp8(v, 8'h80);
        on_backup = 1'b0;
        settle();
        cmp8({7'h00, standby}, 8'h00);
        host.wr(8'h07, 8'h06);
        host.wr(8'h08, 8'h00);
        vcc_fail = 1'b1;
        settle();
        cmp8({7'h00, wave_oe}, 8'h00);
        host.wr(8'h07, 8'h16);
        settle();
        cmp8({7'h00, wave_oe}, 8'h01);
        vcc_fail = 1'b0;
        $display("supply handling done");
        for (i = 3; i > 0; i--)
        begin
            host.wr(8'h07, 8'(i << 1));
            wait_lvl(0, 1'b0, 100);
            wait_lvl(0, 1'b1, 100);
            t0 = $time;
            wait_lvl(0, 1'b0, 100);
            wait_lvl(0, 1'b1, 100);
            cmp_len(int'(($time - t0) / 5), per[i], 0);
        end
        $display("square wave done");
        // fast count rate but disabled, so the bytes must not move
        host.wr(8'h07, 8'h22);
        v = 8'($urandom());
        host.wr(8'h05, v);
        host.wr(8'h06, 8'h5A);
        repeat (40) @(negedge clk);
        host.rd(8'h05, w); cmp8(w, v);
        host.rd(8'h06, w); cmp8(w, 8'h5A);
        host.wr(8'h05, 8'h00);
        host.wr(8'h06, 8'h00);
        $display("counter storage done");
        host.wr(8'h07, 8'h66);
        host.wr(8'h04, 8'h03);
        for (i = 0; i < 40; i++)
            host.rd(8'h04, v);
        cmp8({7'h00, rst_oe}, 8'h00);
        wait_lvl(1, 1'b1, 200);
        t0 = $time;
        host.rd(8'h08, v); cmp8(v, 8'h01);
        cmp8({6'h00, pstate}, {6'h00, PS_RST});
        cmp8({7'h00, irq_oe}, 8'h00);
        cmp8({6'h00, rst_out, irq_out}, 8'h00);
        wait_lvl(1, 1'b0, 20000);
        cmp_len(int'(($time - t0) / 5), 16384, 32);
        host.rd(8'h08, v); cmp8(v, 8'h00);
        $display("reset pulse done");
        on_backup = 1'b1;
        host.wr(8'h07, 8'h6F);
        host.wr(8'h04, 8'h03);
        wait_lvl(2, 1'b1, 200);
        t0 = $time;
        host.wr(8'h08, 8'h00);
        host.wr(8'h07, 8'h6E);
        cmp8({6'h00, pstate}, {6'h00, PS_INT});
        cmp8({7'h00, rst_oe}, 8'h00);
        wait_lvl(2, 1'b0, 20000);
        cmp_len(int'(($time - t0) / 5), 16384, 32);
        host.rd(8'h08, v); cmp8(v, 8'h00);
        on_backup = 1'b0;
        $display("interrupt pulse done");
        // periodic alarm at the one second tick, wave at 1 Hz
        host.wr(8'h07, 8'h41);
        host.wr(8'h04, 8'h01);
        wait_lvl(2, 1'b1, 70000);
        cmp8({7'h00, wave}, 8'h01);
        wait_lvl(0, 1'b0, 4);
        repeat (20) @(negedge clk);
        cmp8({7'h00, wave}, 8'h00);
        host.rd(8'h08, v); cmp8(v, 8'h01);
        host.rd(8'h04, v); cmp8(v, 8'h01);
        cmp8({7'h00, irq_oe}, 8'h01);
        irq_sel = 1'b0;
        settle();
        cmp8({7'h00, irq_oe}, 8'h00);
        irq_sel = 1'b1;
        settle();
        cmp8({7'h00, irq_oe}, 8'h01);
        host.wr(8'h08, 8'h00);
        settle();
        cmp8({7'h00, irq_oe}, 8'h00);
        $display("periodic alarm done");
        tally_and_finish();
    end
endmodule : test_rtc_control_status_regs
